// ==== sim/hcl_eeprom_model.sv ====
// behavioural serial eeprom holding a 16-byte image, byte n = c0 | n
module hcl_eeprom_model (
  // wire levels and fault control
  input wire logic scl,
  input wire logic sda,
  input wire logic nak,
  // open drain pull
  output logic sda_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  int bitn = 0;
  int st = 0;
  logic act = 0;
  logic rd = 0;
  logic [7:0] sh = 8'h00;
  logic [3:0] ptr = 4'h0;
  initial sda_oe = 0;
  // start and stop conditions
  always @(negedge sda) if (scl) begin act = 1; bitn = 0; st = 0; rd = 0; end
  always @(posedge sda) if (scl) act = 0;
  // sample on rising clock; master nack ends the read
  always @(posedge scl) if (act) begin
    if (bitn < 8 && !rd) sh = {sh[6:0], sda};
    if (bitn == 8 && rd && sda) act = 0;
    bitn++;
  end
  // drive on falling clock only, line released otherwise
  always @(negedge scl) if (act) begin
    sda_oe = 0;
    if (bitn == 8 && !rd) begin
      if (st == 0) begin sda_oe = !nak && sh[7:1] == 7'h50; rd = sh[0] && !nak; end
      else begin ptr = sh[3:0]; sda_oe = 1; end
      st++;
    end else if (bitn == 9) begin
      bitn = 0;
      if (rd) begin sh = 8'hC0 | {4'h0, ptr}; ptr++; end
    end
    if (rd && bitn < 8) sda_oe = !sh[7 - bitn];
  end
endmodule : hcl_eeprom_model

// ==== sim/hcl_loader_monitor.sv ====
// assertion checker for the configuration loader ports
module hcl_loader_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // pins and eeprom bus
  input wire logic upstream_power_sense,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_o,
  input wire logic sda_oe,
  // attach and image
  input wire logic attach_ok,
  input wire logic pullup_en,
  input wire logic cfg_valid,
  input wire logic cfg_from_eeprom,
  input wire logic [7:0] cfg_byte1,
  input wire logic [7:0] cfg_byte2,
  input wire logic [7:0] dis_bus_map,
  input wire logic [7:0] maxp_bus,
  input wire logic [7:0] pon_time,
  input wire logic self_powered
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // bus released while chip reset is low
  property p_rel; disable iff (1'b0) !nrst |-> !scl_oe && !sda_oe; endproperty
  a_rel: assert property (p_rel) else $error("eeprom bus driven in reset");
  // no pull-up once the sense has been low a while
  property p_vbus; !upstream_power_sense [*4] |-> !pullup_en; endproperty
  a_vbus: assert property (p_vbus) else $error("pull-up on without power");
  // removal is bounded after loss
  property p_drop; $fell(upstream_power_sense) |-> ##[1:8] !pullup_en; endproperty
  a_drop: assert property (p_drop) else $error("pull-up removal late");
  // attach only after the image is settled
  property p_att; pullup_en |-> attach_ok && cfg_valid; endproperty
  a_att: assert property (p_att) else $error("attach before fetch");
  // clock high phase lasts two quarters
  property p_sclh; $fell(scl_oe) |-> !scl_oe [*8]; endproperty
  a_sclh: assert property (p_sclh) else $error("scl high phase short");
  // open drain: only ever pulls low
  property p_drv; scl_oe || sda_oe |-> !scl_o && !sda_o; endproperty
  a_drv: assert property (p_drv) else $error("bus driven high");
  // a start is followed by the master pulling scl
  property p_start; $rose(sda_oe) && !scl_oe |-> ##[1:16] scl_oe; endproperty
  a_start: assert property (p_start) else $error("no clock after start");
  // built-in defaults when the image is not used
  property p_dflt;
    cfg_valid && !cfg_from_eeprom |-> pon_time == 8'h32 && maxp_bus == 8'h64 && dis_bus_map == 8'h00
      && cfg_byte1 == (self_powered ? 8'h98 : 8'h1C) && cfg_byte2 == (self_powered ? 8'h10 : 8'h90);
  endproperty
  a_dflt: assert property (p_dflt) else $error("wrong default image");
  // power source follows byte one bit 7
  property p_src; cfg_valid |-> self_powered == cfg_byte1[7]; endproperty
  a_src: assert property (p_src) else $error("power source mismatch");
endmodule : hcl_loader_monitor

bind hcl_loader hcl_loader_monitor u_mon (.mclk, .nrst, .upstream_power_sense, .scl_o, .scl_oe, .sda_o,
  .sda_oe, .attach_ok, .pullup_en, .cfg_valid, .cfg_from_eeprom, .cfg_byte1, .cfg_byte2, .dis_bus_map,
  .maxp_bus, .pon_time, .self_powered);

// ==== sim/hcl_loader_tb.sv ====
// self-checking bench for the configuration loader
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
module hcl_loader_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 0, nrst = 1, cfg_sel = 1, pwr_sel = 0, vbus = 1, nak = 0;
  logic scl_o, scl_oe, sda_o, sda_oe, ee_oe, att, pup, vld, from_ee, selfp;
  logic [15:0] vid, pid, did;
  logic [7:0] b1, b2, nrm, dsm, dbm, mps, mpb, hs, hb, pon;
  wire logic scl, sda;
  int fail_count = 0, n_tests = 0;
  // open drain wires with pull-ups
  assign scl = !scl_oe;
  assign sda = !(sda_oe || ee_oe);
  always #20 mclk = ~mclk;
  hcl_loader #(.DROP_CYC(8), .QTR_CYC(4)) dut (.mclk(mclk), .nrst(nrst), .eeprom_cfg_sel(cfg_sel),
    .power_source_select(pwr_sel), .upstream_power_sense(vbus), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .attach_ok(att), .pullup_en(pup), .cfg_valid(vld),
    .cfg_from_eeprom(from_ee), .vendor_id(vid), .product_id(pid), .device_id(did), .cfg_byte1(b1),
    .cfg_byte2(b2), .nonrem_map(nrm), .dis_self_map(dsm), .dis_bus_map(dbm), .maxp_self(mps),
    .maxp_bus(mpb), .hcc_self(hs), .hcc_bus(hb), .pon_time(pon), .self_powered(selfp));
  hcl_eeprom_model u_ee (.scl(scl), .sda(sda), .nak(nak), .sda_oe(ee_oe));
  // verdict and end of run
  task summarize;
    $display("tests %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  task tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task restart;
    @(posedge mclk) nrst <= 0;
    repeat (4) @(posedge mclk);
    nrst <= 1;
  endtask : restart
  task wait_valid;
    for (int i = 0; i < 8000 && vld !== 1'b1; i++) tick(1);
    tick(1);
    `CHK("valid", 1'b1, vld)
  endtask : wait_valid
  // full fetch from the eeprom image
  task t_fetch;
    restart;
    tick(3);
    `CHK("pullup_early", 1'b0, pup)
    `CHK("attach_early", 1'b0, att)
    wait_valid;
    `CHK("from_ee", 1'b1, from_ee)
    `CHK("vid", 16'hC1C0, vid)
    `CHK("pid", 16'hC3C2, pid)
    `CHK("did", 16'hC5C4, did)
    `CHK("cfg1", 8'hC6, b1)
    `CHK("cfg2", 8'hC7, b2)
    `CHK("maps", 24'hC8C9CA, {nrm, dsm, dbm})
    `CHK("maxp_bus", 8'hCC, mpb)
    `CHK("hcc", 16'hCDCE, {hs, hb})
    `CHK("pon", 8'hCF, pon)
    `CHK("self", 1'b1, selfp)
    `CHK("pullup", 1'b1, pup)
  endtask : t_fetch
  // upstream power lost then restored
  task t_vbus;
    @(posedge mclk) vbus <= 0;
    tick(10);
    `CHK("pullup_lost", 1'b0, pup)
    @(posedge mclk) vbus <= 1;
    tick(6);
    `CHK("pullup_back", 1'b1, pup)
  endtask : t_vbus
  // chip reset in mid-fetch releases the bus
  task t_prog;
    restart;
    tick(400);
    @(posedge mclk) nrst <= 0;
    tick(2);
    `CHK("scl_oe", 1'b0, scl_oe)
    `CHK("sda_oe", 1'b0, sda_oe)
    `CHK("attach_rst", 1'b0, att)
  endtask : t_prog
  // address not acknowledged: bus defaults, attach anyway
  task t_nak;
    @(posedge mclk) nak <= 1;
    pwr_sel <= 0;
    restart;
    wait_valid;
    `CHK("from_ee_nak", 1'b0, from_ee)
    `CHK("attach_nak", 1'b1, att)
    `CHK("cfg1_bus", 8'h1C, b1)
    `CHK("cfg2_bus", 8'h90, b2)
    `CHK("maxp_bus_def", 8'h64, mpb)
    `CHK("pon_def", 8'h32, pon)
    `CHK("self_bus", 1'b0, selfp)
  endtask : t_nak
  // no eeprom selected: self-powered defaults
  task t_noee;
    @(posedge mclk) cfg_sel <= 0;
    pwr_sel <= 1;
    restart;
    wait_valid;
    `CHK("cfg1_self", 8'h98, b1)
    `CHK("cfg2_self", 8'h10, b2)
    `CHK("maps_def", 24'h000000, {nrm, dsm, dbm})
    `CHK("maxp_self", 8'h01, mps)
    `CHK("hcc_def", 16'h0164, {hs, hb})
    `CHK("self_self", 1'b1, selfp)
  endtask : t_noee
  // main sequence
  initial begin
    t_fetch;
    t_vbus;
    t_prog;
    t_nak;
    t_noee;
    summarize;
  end
  // watchdog against a hung fetch
  initial begin
    #2_000_000;
    fail_count++;
    summarize;
  end
endmodule : hcl_loader_tb

// ==== src/hcl_loader.sv ====
// hub configuration eeprom loader: i2c master, image store, attach and pull-up gating
// Notes on behaviour
// - no pull-up power while upstream power absent
// - pull-up removed within ten seconds of loss
// - fetch image before attaching upstream
// - single eeprom, 100 kbit/s, 7-bit addresses
// - master drives scl, start, stop, direction
// - no 10-bit addressing, no extensions
// - eeprom slave address is always 1010000
// - eeprom pins released while chip reset low
// - ids: high offset bits 15:8, low 7:0
// - config byte one at 6, defaults 98/1C
// - config byte two at 7, defaults 10/90
// - maps at 8, 9, A default zero
// - max power bytes in 2mA units, bus 64
// - controller current at D and E
// - power-on time at F, default 32
// - power-on time counts 2ms steps
// - config byte one bit 7 selects source
`include "hcl_params.svh"
module hcl_loader #(
  parameter int DROP_CYC = `HCL_DROP_CYC,
  parameter int QTR_CYC = `HCL_QTR_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // configuration choices from pins
  input wire logic eeprom_cfg_sel,
  input wire logic power_source_select,
  input wire logic upstream_power_sense,
  // eeprom bus, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // upstream attach
  output logic attach_ok,
  output logic pullup_en,
  output logic cfg_valid,
  output logic cfg_from_eeprom,
  // configuration image fields
  output logic [15:0] vendor_id,
  output logic [15:0] product_id,
  output logic [15:0] device_id,
  output logic [7:0] cfg_byte1,
  output logic [7:0] cfg_byte2,
  output logic [7:0] nonrem_map,
  output logic [7:0] dis_self_map,
  output logic [7:0] dis_bus_map,
  output logic [7:0] maxp_self,
  output logic [7:0] maxp_bus,
  output logic [7:0] hcc_self,
  output logic [7:0] hcc_bus,
  output logic [7:0] pon_time,
  output logic self_powered
);
  // identity defaults, values arbitrary
  localparam logic [15:0] DEF_VID = 16'h1234;
  localparam logic [15:0] DEF_PID = 16'h5678;
  localparam logic [15:0] DEF_DID = 16'h0001;
  hcl_pkg::hcl_state_e state_ff;
  hcl_pkg::hcl_phase_e phase_ff;
  hcl_pkg::hcl_byte_t img_ff [`HCL_IMG_BYTES];
  logic [15:0] qcnt_ff;
  logic [1:0] quarter_ff;
  logic [3:0] bit_ff;
  logic [3:0] idx_ff;
  logic [7:0] sh_ff;
  logic ack_bad_ff;
  logic got_ff;
  logic [1:0] sda_sync_ff, vb_sync_ff, psel_sync_ff, esel_sync_ff, settle_ff;
  logic [31:0] drop_ff;
  logic tick;

  // two-flop synchronisers on pin inputs; settle_ff marks when they hold real pin values
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sda_sync_ff <= 2'b11;
      vb_sync_ff <= 2'b00;
      psel_sync_ff <= 2'b00;
      esel_sync_ff <= 2'b00;
      settle_ff <= 2'b00;
    end else begin
      sda_sync_ff <= {sda_sync_ff[0], sda_i};
      vb_sync_ff <= {vb_sync_ff[0], upstream_power_sense};
      psel_sync_ff <= {psel_sync_ff[0], power_source_select};
      esel_sync_ff <= {esel_sync_ff[0], eeprom_cfg_sel};
      settle_ff <= {settle_ff[0], 1'b1};
    end
  end

  // quarter bit timer, four quarters per scl period
  assign tick = (qcnt_ff == 16'(QTR_CYC - 1));
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      qcnt_ff <= 16'h0000;
    end else if (tick || state_ff == hcl_pkg::HCL_IDLE) begin
      qcnt_ff <= 16'h0000;
    end else begin
      qcnt_ff <= qcnt_ff + 16'h0001;
    end
  end

  // transmit byte for each write phase: 7-bit address plus direction, or offset 00
  function automatic logic [7:0] tx_byte(input hcl_pkg::hcl_phase_e ph);
    case (ph)
      hcl_pkg::HCL_PH_WADDR: tx_byte = {`HCL_EE_ADDR, 1'b0};
      hcl_pkg::HCL_PH_OFFSET: tx_byte = 8'h00;
      hcl_pkg::HCL_PH_RADDR: tx_byte = {`HCL_EE_ADDR, 1'b1};
      default: tx_byte = 8'hFF;
    endcase
  endfunction : tx_byte

  // i2c master sequencer; reset releases both lines
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= hcl_pkg::HCL_IDLE;
      phase_ff <= hcl_pkg::HCL_PH_WADDR;
      quarter_ff <= 2'd0;
      bit_ff <= 4'd0;
      idx_ff <= 4'd0;
      sh_ff <= 8'h00;
      ack_bad_ff <= 1'b0;
      got_ff <= 1'b0;
      scl_o <= 1'b0;
      scl_oe <= 1'b0;
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      got_ff <= 1'b0;
      case (state_ff)
        hcl_pkg::HCL_IDLE: begin
          if (settle_ff[1] && esel_sync_ff[1]) begin
            state_ff <= hcl_pkg::HCL_START;
            phase_ff <= hcl_pkg::HCL_PH_WADDR;
            quarter_ff <= 2'd0;
          end else if (settle_ff[1]) begin
            state_ff <= hcl_pkg::HCL_DONE;
          end
        end
        hcl_pkg::HCL_START, hcl_pkg::HCL_RSTART: if (tick) begin
          quarter_ff <= quarter_ff + 2'd1;
          // scl high with sda falling forms a start
          case (quarter_ff)
            2'd0: begin scl_oe <= 1'b0; sda_oe <= 1'b0; end
            2'd1: sda_oe <= 1'b1;
            2'd2: scl_oe <= 1'b1;
            default: begin
              state_ff <= hcl_pkg::HCL_SHIFT;
              bit_ff <= 4'd0;
              sh_ff <= tx_byte(phase_ff);
            end
          endcase
        end
        hcl_pkg::HCL_SHIFT: if (tick) begin
          quarter_ff <= quarter_ff + 2'd1;
          case (quarter_ff)
            2'd0: sda_oe <= (phase_ff == hcl_pkg::HCL_PH_READ) ? 1'b0 : ~sh_ff[7];
            2'd1: scl_oe <= 1'b0;
            2'd2: sh_ff <= {sh_ff[6:0], sda_sync_ff[1]};
            default: begin
              scl_oe <= 1'b1;
              bit_ff <= bit_ff + 4'd1;
              if (bit_ff == 4'd7) begin
                state_ff <= hcl_pkg::HCL_ACK;
                if (phase_ff == hcl_pkg::HCL_PH_READ) begin
                  got_ff <= 1'b1;
                end
              end
            end
          endcase
        end
        hcl_pkg::HCL_ACK: if (tick) begin
          quarter_ff <= quarter_ff + 2'd1;
          case (quarter_ff)
            // master acks all reads but the last
            2'd0: sda_oe <= (phase_ff == hcl_pkg::HCL_PH_READ) ? (idx_ff != 4'hF) : 1'b0;
            2'd1: scl_oe <= 1'b0;
            2'd2: ack_bad_ff <= (phase_ff != hcl_pkg::HCL_PH_READ) && sda_sync_ff[1];
            default: begin
              scl_oe <= 1'b1;
              bit_ff <= 4'd0;
              sh_ff <= tx_byte(hcl_pkg::hcl_phase_e'(phase_ff + 2'd1));
              if (ack_bad_ff) begin
                state_ff <= hcl_pkg::HCL_STOP;
              end else if (phase_ff == hcl_pkg::HCL_PH_READ) begin
                idx_ff <= idx_ff + 4'd1;
                state_ff <= (idx_ff == 4'hF) ? hcl_pkg::HCL_STOP : hcl_pkg::HCL_SHIFT;
              end else begin
                phase_ff <= hcl_pkg::hcl_phase_e'(phase_ff + 2'd1);
                state_ff <= (phase_ff == hcl_pkg::HCL_PH_OFFSET) ? hcl_pkg::HCL_RSTART : hcl_pkg::HCL_SHIFT;
              end
            end
          endcase
        end
        hcl_pkg::HCL_STOP: if (tick) begin
          quarter_ff <= quarter_ff + 2'd1;
          // sda rising while scl high forms a stop
          case (quarter_ff)
            2'd0: sda_oe <= 1'b1;
            2'd1: scl_oe <= 1'b0;
            2'd2: sda_oe <= 1'b0;
            default: state_ff <= ack_bad_ff ? hcl_pkg::HCL_FAIL : hcl_pkg::HCL_DONE;
          endcase
        end
        hcl_pkg::HCL_DONE, hcl_pkg::HCL_FAIL: begin
          scl_oe <= 1'b0;
          sda_oe <= 1'b0;
        end
        default: state_ff <= hcl_pkg::HCL_IDLE;
      endcase
    end
  end

  // image store, filled upward from offset 0
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `HCL_IMG_BYTES; i++) begin
        img_ff[i] <= 8'h00;
      end
    end else if (got_ff) begin
      img_ff[idx_ff] <= sh_ff;
    end
  end

  // pull-up gating: immediate off on loss, counter bounds it anyway
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      drop_ff <= 32'h0000_0000;
      pullup_en <= 1'b0;
    end else begin
      drop_ff <= vb_sync_ff[1] ? 32'h0000_0000 : (drop_ff == 32'(DROP_CYC) ? drop_ff : drop_ff + 32'h0000_0001);
      pullup_en <= vb_sync_ff[1] && attach_ok && (drop_ff == 32'h0000_0000);
    end
  end

  logic use_ee, sp;
  assign use_ee = (state_ff == hcl_pkg::HCL_DONE) && esel_sync_ff[1];
  assign sp = use_ee ? img_ff[`HCL_OFF_CFG1][`HCL_CFG1_PWR_BIT] : psel_sync_ff[1];

  // registered configuration outputs once the fetch has settled
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      attach_ok <= 1'b0;
      cfg_valid <= 1'b0;
      cfg_from_eeprom <= 1'b0;
      self_powered <= 1'b0;
      vendor_id <= 16'h0000;
      product_id <= 16'h0000;
      device_id <= 16'h0000;
      cfg_byte1 <= 8'h00;
      cfg_byte2 <= 8'h00;
      nonrem_map <= 8'h00;
      dis_self_map <= 8'h00;
      dis_bus_map <= 8'h00;
      maxp_self <= 8'h00;
      maxp_bus <= 8'h00;
      hcc_self <= 8'h00;
      hcc_bus <= 8'h00;
      pon_time <= 8'h00;
    end else begin
      attach_ok <= (state_ff == hcl_pkg::HCL_DONE) || (state_ff == hcl_pkg::HCL_FAIL);
      cfg_valid <= (state_ff == hcl_pkg::HCL_DONE) || (state_ff == hcl_pkg::HCL_FAIL);
      cfg_from_eeprom <= use_ee;
      self_powered <= sp;
      if (use_ee) begin
        vendor_id <= {img_ff[`HCL_OFF_VID + 4'h1], img_ff[`HCL_OFF_VID]};
        product_id <= {img_ff[`HCL_OFF_PID + 4'h1], img_ff[`HCL_OFF_PID]};
        device_id <= {img_ff[`HCL_OFF_DID + 4'h1], img_ff[`HCL_OFF_DID]};
        cfg_byte1 <= img_ff[`HCL_OFF_CFG1];
        cfg_byte2 <= img_ff[`HCL_OFF_CFG2];
        nonrem_map <= img_ff[`HCL_OFF_NREM];
        dis_self_map <= img_ff[`HCL_OFF_DIS_SELF];
        dis_bus_map <= img_ff[`HCL_OFF_DIS_BUS];
        maxp_self <= img_ff[`HCL_OFF_MAXP_SELF];
        maxp_bus <= img_ff[`HCL_OFF_MAXP_BUS];
        hcc_self <= img_ff[`HCL_OFF_HCC_SELF];
        hcc_bus <= img_ff[`HCL_OFF_HCC_BUS];
        pon_time <= img_ff[`HCL_OFF_PON_TIME];
      end else begin
        vendor_id <= DEF_VID;
        product_id <= DEF_PID;
        device_id <= DEF_DID;
        cfg_byte1 <= sp ? `HCL_CFG1_SELF : `HCL_CFG1_BUS;
        cfg_byte2 <= sp ? `HCL_CFG2_SELF : `HCL_CFG2_BUS;
        nonrem_map <= 8'h00;
        dis_self_map <= 8'h00;
        dis_bus_map <= 8'h00;
        maxp_self <= `HCL_MAXP_SELF_DEF;
        maxp_bus <= `HCL_MAXP_BUS_DEF;
        hcc_self <= `HCL_HCC_SELF_DEF;
        hcc_bus <= `HCL_HCC_BUS_DEF;
        pon_time <= `HCL_PON_DEF;
      end
    end
  end
endmodule : hcl_loader

// ==== src/hcl_params.svh ====
// constants for the hub configuration eeprom loader
`ifndef HCL_PARAMS_SVH
`define HCL_PARAMS_SVH
`define HCL_CLK_HZ 25000000
`define HCL_SCL_HZ 100000
`define HCL_QTR_CYC ((`HCL_CLK_HZ / `HCL_SCL_HZ) / 4)
`define HCL_DROP_SEC 10
`define HCL_DROP_MS 100
`define HCL_DROP_CYC ((`HCL_CLK_HZ / 1000) * `HCL_DROP_MS)
`define HCL_EE_ADDR 7'h50
`define HCL_IMG_BYTES 16
`define HCL_OFF_VID 4'h0
`define HCL_OFF_PID 4'h2
`define HCL_OFF_DID 4'h4
`define HCL_OFF_CFG1 4'h6
`define HCL_OFF_CFG2 4'h7
`define HCL_OFF_NREM 4'h8
`define HCL_OFF_DIS_SELF 4'h9
`define HCL_OFF_DIS_BUS 4'hA
`define HCL_OFF_MAXP_SELF 4'hB
`define HCL_OFF_MAXP_BUS 4'hC
`define HCL_OFF_HCC_SELF 4'hD
`define HCL_OFF_HCC_BUS 4'hE
`define HCL_OFF_PON_TIME 4'hF
`define HCL_CFG1_SELF 8'h98
`define HCL_CFG1_BUS 8'h1C
`define HCL_CFG2_SELF 8'h10
`define HCL_CFG2_BUS 8'h90
`define HCL_MAXP_SELF_DEF 8'h01
`define HCL_MAXP_BUS_DEF 8'h64
`define HCL_HCC_SELF_DEF 8'h01
`define HCL_HCC_BUS_DEF 8'h64
`define HCL_PON_DEF 8'h32
`define HCL_CFG1_PWR_BIT 7
`endif

// ==== src/hcl_pkg.sv ====
// types for the hub configuration eeprom loader
package hcl_pkg;
  typedef enum logic [7:0] {
    HCL_IDLE = 8'b0000_0001,
    HCL_START = 8'b0000_0010,
    HCL_SHIFT = 8'b0000_0100,
    HCL_ACK = 8'b0000_1000,
    HCL_RSTART = 8'b0001_0000,
    HCL_STOP = 8'b0010_0000,
    HCL_DONE = 8'b0100_0000,
    HCL_FAIL = 8'b1000_0000
  } hcl_state_e;
  typedef enum logic [1:0] {
    HCL_PH_WADDR = 2'b00,
    HCL_PH_OFFSET = 2'b01,
    HCL_PH_RADDR = 2'b10,
    HCL_PH_READ = 2'b11
  } hcl_phase_e;
  typedef logic [7:0] hcl_byte_t;
endpackage : hcl_pkg
